// >>> inc/rxp_pkg.sv
// Shared constants and types for the receive port of the transceiver.
// Assumes a 125 MHz core clock and a separate RMII reference clock.

package rxp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int RXP_CLK_PERIOD_NS = 8;
	localparam int RXP_RXCLK_FAST_NS = 40;
	localparam int RXP_RXCLK_SLOW_NS = 400;
	localparam logic [5:0] RXP_DIV_FAST = 6'(RXP_RXCLK_FAST_NS / RXP_CLK_PERIOD_NS);
	localparam logic [5:0] RXP_DIV_SLOW = 6'(RXP_RXCLK_SLOW_NS / RXP_CLK_PERIOD_NS);
	localparam logic [2:0] RXP_STRAP_SETTLE = 3'h3;

	////////////////////////////////////////////////////////////////////////
	// Strap layout
	localparam logic [4:0] RXP_STRAP_DEFAULT = 5'h01;
	localparam int RXP_STRAP_COL_BIT = 0;
	localparam int RXP_STRAP_RXD_LSB = 1;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		RXP_MODE_MII = 2'h0,
		RXP_MODE_RMII = 2'h1,
		RXP_MODE_RGMII = 2'h3
	} rxp_mode_t;

	typedef enum logic [1:0] {
		RXP_ST_SETTLE = 2'h0,
		RXP_ST_LATCH = 2'h1,
		RXP_ST_DRIVE = 2'h3
	} rxp_strap_st_t;

	// Errored nibbles are inverted so a MAC ignoring the error pin still sees bad CRC
	function automatic logic [3:0] rxp_deliver(input logic [3:0] data, input logic err);
		rxp_deliver = err ? ~data : data;
	endfunction : rxp_deliver

endpackage : rxp_pkg

// >>> src/rxp_rmii_xfer.sv
// RMII side of the receive port: carries nibbles from the core clock into the
// reference clock domain and shifts them out as dibits, low pair first.
// Assumes ref_clk runs whenever the port is in RMII mode.
`timescale 1ns/10ps

module rxp_rmii_xfer (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic put_valid, // nibble offered
	input wire logic [4:0] put_word, // error flag and nibble
	output logic put_ready, // crossing free
	input wire logic ref_clk, // shared reference clock
	output logic [1:0] rm_dibit, // receive data pair
	output logic rm_dv, // receive data valid
	output logic rm_er // receive error
);
	import rxp_pkg::*;

	logic busy;
	logic req_tgl;
	logic [4:0] hold_word;
	logic ack_meta;
	logic ack_sync;
	logic ref_rst_meta;
	logic ref_rst_n;
	logic req_meta;
	logic req_sync;
	logic req_seen;
	logic pend_valid;
	logic [4:0] pend_word;
	logic cur_valid;
	logic [4:0] cur_word;
	logic phase;
	wire take = put_valid && !busy;
	wire ack_done = busy && (ack_sync == req_tgl);
	wire new_word = (req_sync != req_seen) && !pend_valid;
	wire shift_free = !cur_valid || phase;

	////////////////////////////////////////////////////////////////////////
	// Core side: hold_word stays put until the acknowledge returns
	assign put_ready = !busy;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			req_tgl <= 1'b0;
			hold_word <= 5'h00;
		end else if (take) begin
			busy <= 1'b1;
			req_tgl <= ~req_tgl;
			hold_word <= put_word;
		end else if (ack_done) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
		end else begin
			ack_meta <= req_seen;
			ack_sync <= ack_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference side
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_rst_meta <= 1'b0;
			ref_rst_n <= 1'b0;
		end else begin
			ref_rst_meta <= 1'b1;
			ref_rst_n <= ref_rst_meta;
		end
	end

	always_ff @(posedge ref_clk or negedge ref_rst_n) begin
		if (!ref_rst_n) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
		end else begin
			req_meta <= req_tgl;
			req_sync <= req_meta;
		end
	end

	// One word of slack hides part of the handshake round trip; a slow core
	// side can still leave gaps, which show as data valid dropping
	always_ff @(posedge ref_clk or negedge ref_rst_n) begin
		if (!ref_rst_n) begin
			req_seen <= 1'b0;
			pend_valid <= 1'b0;
			pend_word <= 5'h00;
		end else if (new_word) begin
			req_seen <= req_sync;
			pend_valid <= 1'b1;
			pend_word <= hold_word;
		end else if (shift_free) begin
			pend_valid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge ref_rst_n) begin
		if (!ref_rst_n) begin
			cur_valid <= 1'b0;
			cur_word <= 5'h00;
			phase <= 1'b0;
		end else if (!shift_free) begin
			phase <= 1'b1;
		end else begin
			cur_valid <= pend_valid;
			cur_word <= pend_valid ? pend_word : 5'h00;
			phase <= 1'b0;
		end
	end

	assign rm_dibit = phase ? cur_word[3:2] : cur_word[1:0];
	assign rm_dv = cur_valid;
	assign rm_er = cur_valid && cur_word[4];

	////////////////////////////////////////////////////////////////////////
	// Checks
	dibit_pair_a: assert property (@(posedge ref_clk) disable iff (!ref_rst_n)
		cur_valid && !phase |=> cur_valid && phase && $stable(cur_word))
		else $error("second dibit of a nibble missing");

	rmii_err_a: assert property (@(posedge ref_clk) disable iff (!ref_rst_n)
		rm_er |-> rm_dv && $past(pend_word[4] || cur_word[4]))
		else $error("rmii error without an errored nibble");

	xfer_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		take |=> !put_ready && hold_word == $past(put_word))
		else $error("crossing word not held");

endmodule : rxp_rmii_xfer

// >>> src/rxp_rx_port.sv
// Receive-side MAC port of the transceiver: clocks decoded nibbles out over
// MII, RMII or RGMII and latches the management address straps at reset.
// Assumes decoded symbols arrive on clk; mode and speed are static per link.
`timescale 1ns/10ps

// Behaviour
// - MII receive clock 25 or 2.5 MHz
// - RGMII receive clock 25 or 2.5 MHz
// - RMII leaves receive clock unused
// - Data valid marks data, independent of carrier
// - RGMII control: valid rising, error falling
// - Error pin high on errored symbol
// - MII error aligned to receive clock
// - RMII error aligned to reference clock
// - Errored data is corrupted by the device
// - RGMII leaves error pin unused
// - Data changes for rising-edge sampling
// - Four bits MII/RGMII, two bits RMII
// - Address strapped from data and collision
module rxp_rx_port (
	input wire logic clk, // core clock, 125 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic ref_clk, // RMII reference clock
	input wire rxp_pkg::rxp_mode_t mode, // interface mode
	input wire logic speed_100, // 1: 100 Mbps, 0: 10 Mbps
	input wire logic sym_valid, // decoded nibble present
	input wire logic [3:0] sym_data, // decoded nibble
	input wire logic sym_error, // nibble came from an error symbol
	output logic sym_ready, // nibble taken this cycle
	output logic rx_clk, // receive clock pin
	output logic rx_ctrl, // data valid or combined control pin
	output logic rx_er, // receive error pin
	input wire logic [3:0] rx_d_in, // receive data pins, input side
	output logic [3:0] rx_d_out, // receive data pins, output side
	output logic rx_d_oe, // receive data pins driven
	input wire logic col_in, // collision pin, input side
	output logic [4:0] mgmt_address_strap, // latched management address
	output logic strap_done // straps latched, pins driving
);
	import rxp_pkg::*;

	logic [3:0] rxd_meta;
	logic [3:0] rxd_sync;
	logic col_meta;
	logic col_sync;
	rxp_strap_st_t state;
	rxp_strap_st_t next_state;
	logic [2:0] settle_cnt;
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic clk_q;
	logic st_valid;
	logic st_err;
	logic [3:0] st_data;
	logic line_valid;
	logic line_err;
	logic [3:0] line_data;
	logic ctrl_q;
	logic rm_put_ready;
	logic [1:0] rm_dibit;
	logic rm_dv;
	logic rm_er;

	wire is_mii = (mode == RXP_MODE_MII);
	wire is_rmii = (mode == RXP_MODE_RMII);
	wire is_rgmii = (mode == RXP_MODE_RGMII);
	wire [5:0] div_len = speed_100 ? RXP_DIV_FAST : RXP_DIV_SLOW;
	wire [5:0] half = div_len >> 1;
	wire wrap = (cnt >= div_len - 6'h01);
	wire tick_take = (cnt == half - 6'h01);
	wire load_line = (cnt == half);
	wire er_phase = (cnt == 6'h00);
	wire take = sym_valid && sym_ready;
	wire [4:0] rm_word = {sym_error, rxp_deliver(sym_data, sym_error)};

	////////////////////////////////////////////////////////////////////////
	// Strap pins come from outside, so they pass two flops first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_meta <= 4'h0;
			rxd_sync <= 4'h0;
			col_meta <= 1'b1;
			col_sync <= 1'b1;
		end else begin
			rxd_meta <= rx_d_in;
			rxd_sync <= rxd_meta;
			col_meta <= col_in;
			col_sync <= col_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strap sequence: pins stay released until the synchronisers have filled
	// with the strap levels, then the address is caught once
	always_comb begin
		next_state = state;
		case (state)
			RXP_ST_SETTLE: begin
				if (settle_cnt == RXP_STRAP_SETTLE)
					next_state = RXP_ST_LATCH;
			end
			RXP_ST_LATCH: next_state = RXP_ST_DRIVE;
			RXP_ST_DRIVE: next_state = RXP_ST_DRIVE;
			default: next_state = RXP_ST_SETTLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= RXP_ST_SETTLE;
			settle_cnt <= 3'h0;
		end else begin
			state <= next_state;
			if (state == RXP_ST_SETTLE)
				settle_cnt <= settle_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmt_address_strap <= RXP_STRAP_DEFAULT;
		end else if (state == RXP_ST_LATCH) begin
			mgmt_address_strap[RXP_STRAP_COL_BIT] <= col_sync;
			mgmt_address_strap[RXP_STRAP_RXD_LSB +: 4] <= rxd_sync;
		end
	end

	assign strap_done = (state == RXP_ST_DRIVE);
	assign rx_d_oe = strap_done;

	////////////////////////////////////////////////////////////////////////
	// Receive clock divider; the line clock is recovered into clk, so it is
	// made here rather than being a second domain
	assign next_cnt = wrap ? 6'h00 : cnt + 6'h01;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 6'h00;
			clk_q <= 1'b0;
		end else begin
			cnt <= next_cnt;
			clk_q <= (next_cnt < half);
		end
	end

	assign rx_clk = clk_q && strap_done && !is_rmii;

	////////////////////////////////////////////////////////////////////////
	// MII and RGMII path: take a nibble, then launch it a cycle after the
	// falling edge so it is settled for the MAC's rising-edge sample
	assign sym_ready = strap_done && (is_rmii ? rm_put_ready : tick_take);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_valid <= 1'b0;
			st_err <= 1'b0;
			st_data <= 4'h0;
		end else if (tick_take) begin
			st_valid <= take;
			st_err <= take && sym_error;
			st_data <= take ? sym_data : 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_valid <= 1'b0;
			line_err <= 1'b0;
			line_data <= 4'h0;
		end else if (load_line) begin
			line_valid <= st_valid;
			line_err <= st_err;
			line_data <= rxp_deliver(st_data, st_err);
		end
	end

	// Control pin: valid for the rising edge, error for the falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= 1'b0;
		end else if (load_line) begin
			ctrl_q <= st_valid;
		end else if (er_phase) begin
			ctrl_q <= line_err;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// RMII path
	rxp_rmii_xfer u_rmii (
		.clk(clk),
		.rst_n(rst_n),
		.put_valid(is_rmii && take),
		.put_word(rm_word),
		.put_ready(rm_put_ready),
		.ref_clk(ref_clk),
		.rm_dibit(rm_dibit),
		.rm_dv(rm_dv),
		.rm_er(rm_er)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin selection
	wire [3:0] pin_data = is_rmii ? {2'b00, rm_dibit} : line_data;
	wire pin_ctrl = is_rmii ? rm_dv : (is_rgmii ? ctrl_q : line_valid);
	wire pin_er = is_rmii ? rm_er : (is_mii && line_err);

	assign rx_d_out = strap_done ? pin_data : 4'h0;
	assign rx_ctrl = strap_done && pin_ctrl;
	assign rx_er = strap_done && pin_er;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence fast_mii_edge_s;
		$rose(rx_clk) && is_mii && speed_100;
	endsequence

	// The first edge after the straps can start a shortened high phase, so it is skipped
	sequence slow_rgmii_edge_s;
		$rose(rx_clk) && is_rgmii && !speed_100 && $past(strap_done);
	endsequence

	sequence ctrl_valid_s;
		rx_ctrl == line_valid;
	endsequence

	sequence ctrl_err_s;
		rx_ctrl == line_err;
	endsequence

	mii_clk_rate_a: assert property (
		fast_mii_edge_s |=> !$rose(rx_clk)[*4] ##1 $rose(rx_clk))
		else $error("mii receive clock not 25 MHz");

	rgmii_clk_rate_a: assert property (
		slow_rgmii_edge_s |-> ##50 $rose(rx_clk))
		else $error("rgmii receive clock not 2.5 MHz");

	rmii_clk_idle_a: assert property (
		is_rmii |-> !rx_clk)
		else $error("receive clock toggles in rmii");

	mii_idle_data_a: assert property (
		is_mii && strap_done && !rx_ctrl |-> rx_d_out == 4'h0)
		else $error("data present without data valid");

	rgmii_ctrl_ddr_a: assert property (
		is_rgmii && $rose(rx_clk) |-> ctrl_valid_s ##1 ctrl_err_s ##1 ctrl_err_s)
		else $error("rgmii control phases wrong");

	mii_err_show_a: assert property (
		is_mii && load_line && st_err |=> rx_er [*3])
		else $error("receive error not shown");

	mii_err_edge_a: assert property (
		is_mii && $changed(rx_er) && $past(strap_done) |-> !rx_clk && $past(load_line))
		else $error("mii error not aligned to receive clock");

	err_corrupt_a: assert property (
		!is_rmii && load_line && st_err |=> line_data == ~$past(st_data))
		else $error("errored nibble delivered intact");

	rgmii_er_idle_a: assert property (
		is_rgmii |-> !rx_er)
		else $error("error pin used in rgmii");

	data_launch_a: assert property (
		!is_rmii && $past(strap_done) && $changed(rx_d_out) |-> !rx_clk)
		else $error("data changes while receive clock high");

	rmii_width_a: assert property (
		is_rmii |-> rx_d_out[3:2] == 2'b00)
		else $error("upper data pins used in rmii");

	strap_catch_a: assert property (
		$rose(strap_done) |-> mgmt_address_strap == $past({rxd_sync, col_sync}))
		else $error("strap address not latched from pins");

	strap_hold_a: assert property (
		strap_done |=> $stable(mgmt_address_strap) && rx_d_oe)
		else $error("strap address changed after latching");

	strap_release_a: assert property (
		!strap_done |-> !rx_d_oe && rx_d_out == 4'h0 && !rx_clk)
		else $error("pins driven before straps latched");

endmodule : rxp_rx_port

// >>> testbench/rxp_mac_model.sv
// Receiving MAC model: records every delivered nibble as {error, nibble}.
// Assumes mode is static between resets and ref_clk runs freely in RMII.
`timescale 1ns/10ps

module rxp_mac_model (
	input wire logic rst_n, // reset, active low
	input wire rxp_pkg::rxp_mode_t mode, // interface mode
	input wire logic rx_clk, // receive clock pin
	input wire logic ref_clk, // shared reference clock
	input wire logic rx_ctrl, // valid or combined control pin
	input wire logic rx_er, // error pin
	input wire logic [3:0] rx_d // receive data pins
);
	import rxp_pkg::*;
	logic [4:0] got[$];
	logic dv_rise;
	logic [3:0] d_rise;
	logic half;
	logic [1:0] lo;

	always @(negedge rst_n) begin
		got.delete();
		half = 1'b0;
		dv_rise = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Data counts only while valid is high, so idle periods are never taken as data
	always @(posedge rx_clk) begin
		dv_rise = rx_ctrl;
		d_rise = rx_d;
		if (mode == RXP_MODE_MII && rx_ctrl) got.push_back({rx_er, rx_d});
	end

	// Falling phase of the control line carries the error bit; a clock cut by reset
	// must not complete a nibble
	always @(negedge rx_clk) begin
		if (mode == RXP_MODE_RGMII && dv_rise && rst_n) got.push_back({rx_ctrl, d_rise});
	end

	////////////////////////////////////////////////////////////////////////
	// Low pair first; error taken with the high pair
	always @(posedge ref_clk) begin
		if (mode == RXP_MODE_RMII && rx_ctrl) begin
			if (half) got.push_back({rx_er, rx_d[1:0], lo});
			else lo = rx_d[1:0];
			half = !half;
		end
	end
endmodule : rxp_mac_model

// >>> testbench/tb_phy_mac_receive_port.sv
// Self-checking bench for the receive port: straps, MII, RGMII and RMII frames.
// Assumes the MAC model beside the port and board pulls given by strap levels.
`timescale 1ns/10ps

`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin fail_count++; \
	$display("BAD %s expected %h seen %h", nm, ex, gt); end end

module tb_phy_mac_receive_port;
	import rxp_pkg::*;
	logic clk, rst_n, ref_clk, speed_100, sym_valid, sym_error, sym_ready;
	logic rx_clk, rx_ctrl, rx_er, rx_d_oe, col_in, strap_done;
	logic [3:0] sym_data, rx_d_in, rx_d_out, strap_d;
	logic [4:0] mgmt_address_strap;
	rxp_mode_t mode;
	int fail_count = 0;
	int check_count = 0;
	int per = 0;
	int cnt = 0;
	logic ck_q = 1'b0;
	logic er_seen, ck_seen;
	logic [3:0] pat[5] = '{4'h5, 4'ha, 4'h3, 4'hc, 4'hf};

	// Board pulls or straps show only while the port leaves the pins released
	assign rx_d_in = rx_d_oe ? rx_d_out : strap_d;

	rxp_rx_port dut (.clk(clk), .rst_n(rst_n), .ref_clk(ref_clk), .mode(mode),
		.speed_100(speed_100), .sym_valid(sym_valid), .sym_data(sym_data),
		.sym_error(sym_error), .sym_ready(sym_ready), .rx_clk(rx_clk), .rx_ctrl(rx_ctrl),
		.rx_er(rx_er), .rx_d_in(rx_d_in), .rx_d_out(rx_d_out), .rx_d_oe(rx_d_oe),
		.col_in(col_in), .mgmt_address_strap(mgmt_address_strap), .strap_done(strap_done));

	rxp_mac_model mac (.rst_n(rst_n), .mode(mode), .rx_clk(rx_clk), .ref_clk(ref_clk),
		.rx_ctrl(rx_ctrl), .rx_er(rx_er), .rx_d(rx_d_out));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		ref_clk = 1'b0;
		#3;
		forever #16 ref_clk = ~ref_clk;
	end

	// Receive clock period in core cycles, and sticky activity flags
	always @(negedge clk) begin
		if (rx_er) er_seen = 1'b1;
		if (rx_clk) ck_seen = 1'b1;
		cnt++;
		if (rx_clk && !ck_q) begin
			per = cnt;
			cnt = 0;
		end
		ck_q = rx_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	task automatic do_reset(input rxp_mode_t m, input logic s, input logic [4:0] strap);
		int n;
		@(negedge clk);
		rst_n = 1'b0;
		mode = m;
		speed_100 = s;
		strap_d = strap[4:1];
		col_in = strap[0];
		repeat (12) @(negedge clk);
		er_seen = 1'b0;
		ck_seen = 1'b0;
		per = 0;
		rst_n = 1'b1;
		n = 0;
		while (strap_done !== 1'b1 && n < 20) begin
			`CHK("pins released", 1'b0, rx_d_oe)
			@(negedge clk);
			n++;
		end
		`CHK("straps latched", 1'b1, strap_done)
		`CHK("strap address", strap, mgmt_address_strap)
		col_in = ~strap[0];
		strap_d = ~strap[4:1];
		repeat (8) @(negedge clk);
		`CHK("address held", strap, mgmt_address_strap)
	endtask : do_reset

	// Offers five nibbles back to back, the third one errored, then checks delivery
	task automatic send_check();
		int n;
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			sym_valid = 1'b1;
			sym_data = pat[i];
			sym_error = (i == 2);
			n = 0;
			while (sym_ready !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			@(posedge clk);
		end
		@(negedge clk);
		sym_valid = 1'b0;
		sym_error = 1'b0;
		n = 0;
		while (mac.got.size() < 5 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		`CHK("nibble count", 5, mac.got.size())
		for (int i = 0; i < 5; i++) begin
			`CHK("nibble", {i == 2, (i == 2) ? ~pat[i] : pat[i]}, mac.got[i])
		end
	endtask : send_check

	////////////////////////////////////////////////////////////////////////
	task automatic test_mii_fast();
		do_reset(RXP_MODE_MII, 1'b1, 5'h01);
		send_check();
		`CHK("mii period", RXP_RXCLK_FAST_NS / RXP_CLK_PERIOD_NS, per)
		`CHK("mii error pin", 1'b1, er_seen)
	endtask : test_mii_fast

	task automatic test_mii_slow();
		do_reset(RXP_MODE_MII, 1'b0, 5'h14);
		send_check();
		`CHK("mii slow period", RXP_RXCLK_SLOW_NS / RXP_CLK_PERIOD_NS, per)
	endtask : test_mii_slow

	task automatic test_rgmii();
		do_reset(RXP_MODE_RGMII, 1'b1, 5'h0b);
		send_check();
		`CHK("rgmii period", RXP_RXCLK_FAST_NS / RXP_CLK_PERIOD_NS, per)
		`CHK("rgmii error pin", 1'b0, er_seen)
	endtask : test_rgmii

	task automatic test_rgmii_slow();
		do_reset(RXP_MODE_RGMII, 1'b0, 5'h06);
		send_check();
		`CHK("rgmii slow period", RXP_RXCLK_SLOW_NS / RXP_CLK_PERIOD_NS, per)
		`CHK("rgmii slow error pin", 1'b0, er_seen)
	endtask : test_rgmii_slow

	task automatic test_rmii();
		do_reset(RXP_MODE_RMII, 1'b1, 5'h1e);
		send_check();
		`CHK("rmii clock unused", 1'b0, ck_seen)
		`CHK("rmii error pin", 1'b1, er_seen)
	endtask : test_rmii

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		mode = RXP_MODE_MII;
		speed_100 = 1'b1;
		sym_valid = 1'b0;
		sym_data = 4'h0;
		sym_error = 1'b0;
		strap_d = 4'h0;
		col_in = 1'b1;
		test_mii_fast();
		test_mii_slow();
		test_rgmii();
		test_rgmii_slow();
		test_rmii();
		finish_test();
	end

	// Whole run needs well under 10,000 core cycles
	initial begin
		#400000;
		fail_count++;
		finish_test();
	end
endmodule : tb_phy_mac_receive_port
